// ---- src/frs_pkg.sv ----
// constants, state encoding and carriers for the flash read and status block
package frs_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int SEC_W  = 3;
  localparam int NSEC   = 8;
  localparam int AW     = SEC_W + ADDR_W;

  localparam logic [NSEC-1:0] MAIN_MASK = 8'h0F;
  localparam logic [NSEC-1:0] BOOT_MASK = 8'h30;

  // ----------------------------------------------------------------
  // instruction bytes and addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_UNLK1 = 8'hAA;
  localparam logic [7:0]  CMD_UNLK2 = 8'h55;
  localparam logic [7:0]  CMD_PROG  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE = 8'h80;
  localparam logic [7:0]  CMD_SECT  = 8'h30;
  localparam logic [7:0]  CMD_BULK  = 8'h10;
  localparam logic [7:0]  CMD_PROT  = 8'h90;
  localparam logic [7:0]  CMD_RESET = 8'hF0;
  localparam logic [11:0] ADR_UNLK1 = 12'h555;
  localparam logic [11:0] ADR_UNLK2 = 12'hAAA;

  localparam logic [7:0]  ERASED    = 8'hFF;
  localparam logic [7:0]  PROT_YES  = 8'h01;
  localparam logic [7:0]  PROT_NO   = 8'h00;
  localparam logic [1:0]  PROT_LOW2 = 2'h2;

  // ----------------------------------------------------------------
  // status byte bit positions
  // ----------------------------------------------------------------
  localparam int POLL_POS = 7;
  localparam int TGL_POS  = 6;
  localparam int ERR_POS  = 5;
  localparam int EWIN_POS = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS  = 25;
  localparam int EWIN_US = 100;
  localparam int PWAIT_US = 100;
  localparam int GAP_US  = 80;
  localparam int PROG_US = 10;
  localparam logic [15:0] EWIN_CYC  = 16'((EWIN_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] PWAIT_CYC = 16'((PWAIT_US * 1000) / CLK_NS);
  localparam logic [15:0] GAP_CYC   = 16'((GAP_US * 1000) / CLK_NS);
  localparam logic [15:0] PROG_CYC  = 16'((PROG_US * 1000) / CLK_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    ST_READ   = 12'h001,
    ST_C1     = 12'h002,
    ST_C2     = 12'h004,
    ST_PROG_D = 12'h008,
    ST_E3     = 12'h010,
    ST_E4     = 12'h020,
    ST_E5     = 12'h040,
    ST_EWIN   = 12'h080,
    ST_ERASE  = 12'h100,
    ST_PROG   = 12'h200,
    ST_FAIL   = 12'h400,
    ST_PROT   = 12'h800
  } frs_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } frs_bus_s;

  typedef struct packed {
    frs_state_e      st;
    logic [15:0]     timer;
    logic [NSEC-1:0] mask;
    logic [AW-1:0]   cnt;
    logic [AW-1:0]   padr;
    logic [7:0]      pdata;
    logic            tgl;
    logic            err;
    logic            ewin;
    logic            rdy;
    logic [7:0]      rdata;
  } frs_regs_s;

  localparam frs_regs_s FRS_RST = '{st: ST_READ, timer: 16'h0000, mask: 8'h00,
    cnt: 9'h000, padr: 9'h000, pdata: 8'h00, tgl: 1'b0, err: 1'b0,
    ewin: 1'b1, rdy: 1'b1, rdata: 8'h00};

endpackage

// ---- src/frs_flash.sv ----
// flash array with instruction decode, embedded algorithms and status reads
`timescale 1ns/1ps
// ------------------------------------------------------------------
// How it works
// RL1: after reset or reset instruction both banks read the array like a rom
// RL2: three writes then a read at xx02h returns 01h protected, 00h not
// RL3: reading during program returns inverted bit seven of data being written
// RL4: status is valid after the fourth or sixth instruction write
// RL5: host reads status at the programmed byte or inside erased sector
// RL6: poll bit reads zero during erase, stored value afterwards
// RL7: program aimed at a protected sector is dropped, array untouched
// RL8: erase of only protected sectors holds poll at zero about 100us
// RL9: each status read during a busy operation inverts the toggle bit
// RL10: after completion toggling stops and reads return the array
// RL11: all-protected erase toggles for about 100us then returns data
// RL12: error bit is zero normally, one on program or erase failure
// RL13: trying to raise a zero bit to one during program sets error
// RL14: only the reset instruction clears the error bit
// RL15: erase window bit zero for 100us, one on expiry or extra sector
// RL16: status byte: poll 7, toggle 6, error 5, window 3
// RL17: erase writes ffh per sector or bank, program only clears bits
// RL18: erase status reads anywhere in the selected sector give poll and error
// RL19: host polls until poll bit matches intended bit seven
// RL20: host treats two equal toggle reads as completion
// RL21: host rereads the byte after programming to compare it
// RL22: ready busy pin is low during program or erase, high otherwise; the code leaves it high in ST_FAIL after a failed program
// RL23: instructions open with aah at 555h and 55h at aaah
// RL24: a bad byte or long gap returns the logic to array read
// RL25: toggle flop cleared at operation start, inverted per status read
// RL26: while busy, status replaces array data on reads
// ------------------------------------------------------------------
module frs_flash
  import frs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire frs_bus_s    bus_i,
  input  wire logic [3:0]  main_bank_sector_selects_i,
  input  wire logic [1:0]  boot_bank_sector_selects_i,
  input  wire logic [5:0]  sector_prot_i,
  output logic      [7:0]  rdata_o,
  output logic             ready_busy_pin_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SEC_W-1:0] sec_idx(input logic [3:0] m,
                                               input logic [1:0] b);
    logic [SEC_W-1:0] v;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) v = SEC_W'(i);
    end
    for (int i = 0; i < 2; i++) begin
      if (b[i]) v = SEC_W'(4 + i);
    end
    return v;
  endfunction

  function automatic logic is_busy(input frs_state_e s);
    return (s == ST_PROG) || (s == ST_ERASE) || (s == ST_EWIN) || (s == ST_FAIL);
  endfunction

  // ----------------------------------------------------------------
  // reset release and state
  // ----------------------------------------------------------------
  logic [1:0]       rst_sync_r;
  logic             rst_n;
  frs_regs_s        r;
  frs_regs_s        r_nxt;
  logic [7:0]       mem [0:(1<<AW)-1];
  logic             mem_we;
  logic [AW-1:0]    mem_wa;
  logic [7:0]       mem_wd;
  logic [7:0]       arr_q;
  logic [7:0]       prg_q;
  logic [7:0]       rd_val;
  logic [7:0]       stat;
  logic [SEC_W-1:0] cur_idx;
  logic [AW-1:0]    cur_a;
  logic [NSEC-1:0]  prot8;
  logic [NSEC-1:0]  sec_bit;
  logic             sel_any;
  logic             main_any;
  logic             wr_ok;
  logic             tmo;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign main_any = |main_bank_sector_selects_i;
  assign sel_any  = main_any | (|boot_bank_sector_selects_i);
  assign cur_idx  = sec_idx(main_bank_sector_selects_i, boot_bank_sector_selects_i);
  assign cur_a    = {cur_idx, bus_i.addr[ADDR_W-1:0]};
  assign prot8    = {2'h0, sector_prot_i};
  assign sec_bit  = NSEC'(1) << cur_idx;
  assign wr_ok    = bus_i.wr && sel_any;
  assign tmo      = (r.timer == 16'h0000);
  assign arr_q    = mem[cur_a];
  assign prg_q    = mem[r.padr];

  function automatic logic hit(input logic [7:0] d, input logic [11:0] a);
    return wr_ok && (bus_i.wdata == d) && (bus_i.addr[11:0] == a);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt  = r;
    mem_we = 1'b0;
    mem_wa = cur_a;
    mem_wd = ERASED;
    rd_val = arr_q;
    stat   = 8'h00;
    if (!tmo) r_nxt.timer = r.timer - 16'h0001;
    unique case (r.st)
      ST_READ: begin
        if (hit(CMD_UNLK1, ADR_UNLK1)) begin // RL23
          r_nxt.st    = ST_C1;
          r_nxt.timer = GAP_CYC;
        end
      end
      ST_C1: begin
        if (hit(CMD_UNLK2, ADR_UNLK2)) begin // RL23
          r_nxt.st    = ST_C2;
          r_nxt.timer = GAP_CYC;
        end else if (wr_ok || tmo) begin
          r_nxt.st = ST_READ; // RL24
        end
      end
      ST_C2: begin
        r_nxt.timer = GAP_CYC;
        if (hit(CMD_PROG, ADR_UNLK1)) r_nxt.st = ST_PROG_D;
        else if (hit(CMD_ERASE, ADR_UNLK1)) r_nxt.st = ST_E3;
        else if (hit(CMD_PROT, ADR_UNLK1)) r_nxt.st = ST_PROT; // RL2
        else if (wr_ok || tmo) r_nxt.st = ST_READ; // RL24
        else r_nxt.timer = r.timer - 16'h0001;
      end
      ST_PROG_D: begin
        if (wr_ok) begin
          r_nxt.padr  = cur_a;
          r_nxt.pdata = bus_i.wdata;
          r_nxt.tgl   = 1'b0; // RL25
          if (prot8[cur_idx]) begin
            r_nxt.st = ST_READ; // RL7
          end else if ((bus_i.wdata & ~arr_q) != 8'h00) begin
            r_nxt.st  = ST_FAIL; // RL13
            r_nxt.err = 1'b1; // RL12
          end else begin
            r_nxt.st    = ST_PROG; // RL4
            r_nxt.timer = PROG_CYC;
          end
        end else if (tmo) begin
          r_nxt.st = ST_READ; // RL24
        end
      end
      ST_E3: begin
        if (hit(CMD_UNLK1, ADR_UNLK1)) begin
          r_nxt.st    = ST_E4;
          r_nxt.timer = GAP_CYC;
        end else if (wr_ok || tmo) begin
          r_nxt.st = ST_READ; // RL24
        end
      end
      ST_E4: begin
        if (hit(CMD_UNLK2, ADR_UNLK2)) begin
          r_nxt.st    = ST_E5;
          r_nxt.timer = GAP_CYC;
        end else if (wr_ok || tmo) begin
          r_nxt.st = ST_READ; // RL24
        end
      end
      ST_E5: begin
        r_nxt.tgl = 1'b0; // RL25
        if (wr_ok && bus_i.wdata == CMD_SECT) begin
          r_nxt.mask  = sec_bit;
          r_nxt.st    = ST_EWIN; // RL4
          r_nxt.timer = EWIN_CYC;
          r_nxt.ewin  = 1'b0; // RL15
        end else if (hit(CMD_BULK, ADR_UNLK1)) begin
          r_nxt.mask  = (main_any ? MAIN_MASK : BOOT_MASK) & ~prot8; // RL17
          r_nxt.st    = ST_ERASE;
          r_nxt.cnt   = '0;
          r_nxt.timer = PWAIT_CYC;
        end else if (wr_ok || tmo) begin
          r_nxt.st  = ST_READ; // RL24
          r_nxt.tgl = r.tgl;
        end
      end
      ST_EWIN: begin
        if (wr_ok && bus_i.wdata == CMD_SECT) begin
          r_nxt.mask  = r.mask | sec_bit;
          r_nxt.timer = EWIN_CYC;
          r_nxt.ewin  = 1'b1; // RL15
        end else if (wr_ok) begin
          r_nxt.st   = ST_READ; // RL24
          r_nxt.mask = '0;
          r_nxt.ewin = 1'b1;
        end else if (tmo) begin
          r_nxt.st    = ST_ERASE;
          r_nxt.mask  = r.mask & ~prot8; // RL8
          r_nxt.cnt   = '0;
          r_nxt.ewin  = 1'b1; // RL15
          r_nxt.timer = PWAIT_CYC;
        end
      end
      ST_ERASE: begin
        // every protected target leaves an empty mask: just wait, erase nothing
        if (r.mask == '0) begin
          if (tmo) r_nxt.st = ST_READ; // RL8 RL11
        end else begin
          mem_we    = r.mask[r.cnt[AW-1:ADDR_W]]; // RL17
          mem_wa    = r.cnt;
          r_nxt.cnt = r.cnt + AW'(1);
          if (&r.cnt) begin
            r_nxt.st   = ST_READ; // RL10
            r_nxt.mask = '0;
          end
        end
      end
      ST_PROG: begin
        if (tmo) begin
          mem_we   = 1'b1;
          mem_wa   = r.padr;
          mem_wd   = prg_q & r.pdata; // RL17
          r_nxt.st = ST_READ; // RL10
        end
      end
      ST_FAIL, ST_PROT: begin
        if (wr_ok && bus_i.wdata == CMD_RESET) begin
          r_nxt.st  = ST_READ; // RL1
          r_nxt.err = 1'b0; // RL14
        end
      end
      default: begin
        r_nxt.st = ST_READ;
      end
    endcase

    // status byte; unguaranteed bits read zero
    stat[POLL_POS] = (r.st == ST_PROG || r.st == ST_FAIL) ? ~r.pdata[7] : 1'b0; // RL3 RL6
    stat[TGL_POS]  = r.tgl;
    stat[ERR_POS]  = r.err; // RL12 RL18
    stat[EWIN_POS] = r.ewin; // RL16
    if (bus_i.rd) begin
      if (is_busy(r.st) && sel_any) begin
        rd_val    = stat; // RL26
        r_nxt.tgl = ~r.tgl; // RL9
      end else if (r.st == ST_PROT && !bus_i.addr[6] && bus_i.addr[1:0] == PROT_LOW2) begin
        rd_val = prot8[cur_idx] ? PROT_YES : PROT_NO; // RL2
      end
      r_nxt.rdata = rd_val; // RL1
    end
    r_nxt.rdy = !(r_nxt.st == ST_PROG || r_nxt.st == ST_ERASE
                  || r_nxt.st == ST_EWIN); // RL22
  end

  // ----------------------------------------------------------------
  // registers and array
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= FRS_RST; // RL1
    end else begin
      r <= r_nxt;
    end
  end

  // array contents are not reset: they are non-volatile by nature
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign rdata_o          = r.rdata;
  assign ready_busy_pin_o = r.rdy;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  logic stat_rd;
  assign stat_rd = bus_i.rd && sel_any && is_busy(r.st);

  property p_busy_pin;
    (r.st == ST_PROG || r.st == ST_ERASE) |-> !ready_busy_pin_o;
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy pin high during op"); // RL22

  property p_prog_poll;
    (bus_i.rd && sel_any && r.st == ST_PROG) |=> (rdata_o[7] != r.pdata[7]);
  endproperty
  a_prog_poll: assert property (p_prog_poll) else $error("poll bit not inverted"); // RL3

  property p_erase_poll;
    (bus_i.rd && sel_any && r.st == ST_ERASE) |=> !rdata_o[7];
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("poll bit not zero"); // RL6

  property p_toggle;
    stat_rd |=> (rdata_o[TGL_POS] == $past(r.tgl)) && (r.tgl != $past(r.tgl));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not flip"); // RL9

  property p_prot_prog;
    (r.st == ST_PROG_D && wr_ok && prot8[cur_idx]) |=> (r.st == ST_READ);
  endproperty
  a_prot_prog: assert property (p_prot_prog) else $error("protected program run"); // RL7

  property p_err_clear;
    $fell(r.err) |-> $past(wr_ok && bus_i.wdata == CMD_RESET);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error cleared wrongly"); // RL14

  property p_ewin_start;
    (r.st == ST_E5 && wr_ok && bus_i.wdata == CMD_SECT)
      |=> (r.st == ST_EWIN && !r.ewin && r.timer == EWIN_CYC);
  endproperty
  a_ewin_start: assert property (p_ewin_start) else $error("window not started"); // RL15

  property p_gap;
    (r.st == ST_C1 && tmo && !bus_i.wr) |=> (r.st == ST_READ);
  endproperty
  a_gap: assert property (p_gap) else $error("gap timeout ignored"); // RL24

  property p_prog_clear_only;
    (r.st == ST_PROG && mem_we) |=> (prg_q == ($past(prg_q) & r.pdata));
  endproperty
  a_prog_clear_only: assert property (p_prog_clear_only) else $error("bit raised"); // RL17

  property p_tgl_start;
    $rose(r.st == ST_PROG) |-> !r.tgl;
  endproperty
  a_tgl_start: assert property (p_tgl_start) else $error("toggle not cleared"); // RL25

  c_prog_done:  cover property (r.st == ST_PROG ##1 r.st == ST_READ);
  c_erase_run:  cover property (r.st == ST_EWIN ##1 r.st == ST_ERASE);
  c_prot_query: cover property (r.st == ST_PROT && bus_i.rd);
  c_fail:       cover property (r.st == ST_FAIL);

endmodule

// ---- tb/frs_host_model.sv ----
// bus master model of the microcontroller core on the flash port
`timescale 1ns/1ps
module frs_host_model
  import frs_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output frs_bus_s        bus_o,
  output logic      [3:0] main_bank_sector_selects_o,
  output logic      [1:0] boot_bank_sector_selects_o
);
  initial begin
    bus_o = '0;
    {boot_bank_sector_selects_o, main_bank_sector_selects_o} = 6'h00;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines show the inverse so a stale value never reads as valid
  task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w,
                      input logic [5:0] sel);
    @(posedge mclk_i);
    bus_o <= '{addr: a, wdata: d, wr: w, rd: ~w};
    {boot_bank_sector_selects_o, main_bank_sector_selects_o} <= sel;
    @(posedge mclk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    {boot_bank_sector_selects_o, main_bank_sector_selects_o} <= 6'h00;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [5:0] sel);
    xfer(a, d, 1'b1, sel);
  endtask

  task automatic rd(input logic [15:0] a, input logic [5:0] sel, output logic [7:0] d);
    xfer(a, 8'h00, 1'b0, sel);
    #1 d = rdata_i;
  endtask

  // ----------------------------------------------------------------
  // instructions
  // ----------------------------------------------------------------
  task automatic unlock(input logic [5:0] sel);
    wr({4'h0, ADR_UNLK1}, CMD_UNLK1, sel);
    wr({4'h0, ADR_UNLK2}, CMD_UNLK2, sel);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic [5:0] sel);
    unlock(sel);
    wr({4'h0, ADR_UNLK1}, CMD_PROG, sel);
    wr(a, d, sel);
  endtask

  task automatic erase_hdr(input logic [5:0] sel);
    unlock(sel);
    wr({4'h0, ADR_UNLK1}, CMD_ERASE, sel);
    unlock(sel);
  endtask

  task automatic query(input logic [5:0] sel);
    unlock(sel);
    wr({4'h0, ADR_UNLK1}, CMD_PROT, sel);
  endtask

  // error seen means poll is read once more, it may have moved with it
  task automatic poll_done(input logic [15:0] a, input logic [5:0] sel, input logic e7,
                           output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 6000 && !ok; i++) begin
      rd(a, sel, d);
      ok = (d[POLL_POS] === e7) && (d[ERR_POS] === 1'b0);
      if (!ok && d[ERR_POS] === 1'b1) begin
        rd(a, sel, d);
        ok = (d[POLL_POS] === e7);
        break;
      end
    end
  endtask

  task automatic toggle_done(input logic [15:0] a, input logic [5:0] sel, output logic ok);
    logic [7:0] p;
    logic [7:0] q;
    ok = 1'b0;
    rd(a, sel, p);
    // once toggling stops the byte is array data, so its bit 5 is not an error flag
    for (int i = 0; i < 6000 && !ok; i++) begin
      rd(a, sel, q);
      ok = (q[TGL_POS] === p[TGL_POS]);
      if (!ok && q[ERR_POS] === 1'b1) begin
        p = q;
        rd(a, sel, q);
        ok = (q[TGL_POS] === p[TGL_POS]);
        break;
      end
      p = q;
    end
  endtask
endmodule

// ---- tb/frs_flash_tb_top.sv ----
// self-checking bench for the flash read and status block
`timescale 1ns/1ps
module frs_flash_tb_top
  import frs_pkg::*;
();
  localparam logic [5:0] S0    = 6'h01;
  localparam logic [5:0] S1    = 6'h02;
  localparam int         LIMIT = 40000;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [5:0] prot = 6'h00;
  frs_bus_s   bus;
  logic [3:0] msel;
  logic [1:0] bsel;
  logic [7:0] rdata;
  logic       rdy;
  logic [7:0] d;
  logic       ok;
  int         num_errors = 0;
  int         checked = 0;
  int         cyc = 0;
  int         run = 0;
  int         last_busy = 0;

  always #12.5 mclk = ~mclk;

  frs_flash DUT (.mclk_i(mclk), .rst_n_i(rst_n), .bus_i(bus),
    .main_bank_sector_selects_i(msel), .boot_bank_sector_selects_i(bsel),
    .sector_prot_i(prot), .rdata_o(rdata), .ready_busy_pin_o(rdy));

  frs_host_model host (.mclk_i(mclk), .rdata_i(rdata), .bus_o(bus),
    .main_bank_sector_selects_o(msel), .boot_bank_sector_selects_o(bsel));

  // ----------------------------------------------------------------
  // busy length and run limit
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rdy === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_busy <= run;
      run <= 0;
    end
  end

  always @(posedge mclk) begin
    if (cyc == LIMIT) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // compares
  // ----------------------------------------------------------------
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // bits 4,2,1,0 carry no promised value, so they are masked off
  task automatic chk_stat(input logic [7:0] exp, input logic [7:0] got);
    chk_byte("status", exp & 8'hE8, got & 8'hE8);
  endtask

  task automatic chk_range(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", name, lo, hi, got);
    end
  endtask

  function automatic logic [7:0] st(input int p, input int t, input int e, input int w);
    return {p[0], t[0], e[0], 1'b0, w[0], 3'b000};
  endfunction

  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sector_erase();
    host.erase_hdr(S0);
    host.wr(16'h0000, CMD_SECT, S0);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 0, 0, 0), d);
    chk_byte("ready", 8'h00, {7'h00, rdy});
    host.wr(16'h0000, CMD_SECT, S1);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 1, 0, 1), d);
    host.toggle_done(16'h0003, S0, ok);
    chk_byte("toggle done", 8'h01, {7'h00, ok});
    chk_range("erase busy", int'(EWIN_CYC) + 512, int'(EWIN_CYC) + 600, last_busy);
    host.rd(16'h0003, S0, d);
    chk_byte("erased byte", ERASED, d);
    host.rd(16'h0003, S1, d);
    chk_byte("erased byte", ERASED, d);
  endtask

  task automatic t_program();
    host.prog(16'h0003, 8'hA5, S0);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 0, 0, 1), d);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 1, 0, 1), d);
    host.poll_done(16'h0003, S0, 1'b1, ok);
    chk_byte("poll done", 8'h01, {7'h00, ok});
    host.rd(16'h0003, S0, d);
    chk_byte("programmed byte", 8'hA5, d);
    chk_range("program busy", int'(PROG_CYC), int'(PROG_CYC) + 4, last_busy);
  endtask

  task automatic t_prog_fail();
    host.prog(16'h0003, 8'hF0, S0);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 0, 1, 1), d);
    repeat (2 * PROG_CYC) @(posedge mclk);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 1, 1, 1), d);
    host.wr(16'h0000, CMD_RESET, S0);
    host.rd(16'h0003, S0, d);
    chk_byte("byte after fail", 8'hA5, d);
  endtask

  task automatic t_prot_prog();
    host.prog(16'h0005, 8'h3C, S1);
    host.poll_done(16'h0005, S1, 1'b0, ok);
    chk_byte("poll done", 8'h01, {7'h00, ok});
    @(posedge mclk);
    prot <= 6'h02;
    host.prog(16'h0005, 8'h00, S1);
    host.rd(16'h0005, S1, d);
    chk_byte("ready", 8'h01, {7'h00, rdy});
    chk_byte("protected byte", 8'h3C, d);
  endtask

  task automatic t_prot_erase();
    host.erase_hdr(S1);
    host.wr(16'h0000, CMD_SECT, S1);
    repeat (EWIN_CYC + 16) @(posedge mclk);
    host.rd(16'h0005, S1, d);
    chk_stat(st(0, 0, 0, 1), d);
    host.toggle_done(16'h0005, S1, ok);
    chk_byte("toggle done", 8'h01, {7'h00, ok});
    chk_range("guarded busy", int'(EWIN_CYC + PWAIT_CYC), int'(EWIN_CYC + PWAIT_CYC) + 16,
              last_busy);
    host.rd(16'h0005, S1, d);
    chk_byte("protected byte", 8'h3C, d);
  endtask

  task automatic t_query();
    host.query(S1);
    host.rd(16'h0002, S1, d);
    chk_byte("protect status", PROT_YES, d);
    host.rd(16'h0002, S0, d);
    chk_byte("protect status", PROT_NO, d);
    host.wr(16'h0000, CMD_RESET, S0);
    host.rd(16'h0005, S1, d);
    chk_byte("array after reset", 8'h3C, d);
  endtask

  task automatic t_bad_seq();
    host.wr({4'h0, ADR_UNLK1}, CMD_UNLK1, S0);
    host.wr({4'h0, ADR_UNLK2}, 8'h12, S0);
    host.wr({4'h0, ADR_UNLK1}, CMD_PROG, S0);
    host.wr(16'h0007, 8'h00, S0);
    host.rd(16'h0007, S0, d);
    chk_byte("ready", 8'h01, {7'h00, rdy});
    chk_byte("untouched byte", ERASED, d);
    host.wr({4'h0, ADR_UNLK1}, CMD_UNLK1, S0);
    repeat (GAP_CYC + 4) @(posedge mclk);
    host.wr({4'h0, ADR_UNLK2}, CMD_UNLK2, S0);
    host.wr({4'h0, ADR_UNLK1}, CMD_PROG, S0);
    host.wr(16'h0007, 8'h00, S0);
    host.rd(16'h0007, S0, d);
    chk_byte("byte after gap", ERASED, d);
  endtask

  task automatic t_bulk();
    host.erase_hdr(S0);
    host.wr({4'h0, ADR_UNLK1}, CMD_BULK, S0);
    host.rd(16'h0003, S0, d);
    chk_stat(st(0, 0, 0, 1), d);
    host.poll_done(16'h0003, S0, 1'b1, ok);
    chk_byte("poll done", 8'h01, {7'h00, ok});
    host.rd(16'h0003, S0, d);
    chk_byte("bulk erased byte", ERASED, d);
    host.rd(16'h0005, S1, d);
    chk_byte("protected byte", 8'h3C, d);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_byte("rdata", 8'h00, rdata);
    chk_byte("ready", 8'h01, {7'h00, rdy});
    t_sector_erase();
    t_program();
    t_prog_fail();
    t_prot_prog();
    t_prot_erase();
    t_query();
    t_bad_seq();
    t_bulk();
    print_verdict();
  end
endmodule
